// ---- pkg/bld_params.svh ----
// constants for the bridge link diagnostic configuration register bank
// assumes dword-aligned configuration byte offsets on an 8-bit address
`ifndef BLD_PARAMS_SVH
`define BLD_PARAMS_SVH

// configuration byte offsets
`define BLD_OFS_DIAG 8'hC8
`define BLD_OFS_SUBSYS 8'hD0
`define BLD_OFS_GENCTL 8'hD4
`define BLD_OFS_SSID 8'h44

// reset values
`define BLD_RST_DIAG 32'h32142000
`define BLD_RST_SUBSYS 32'h00000000
`define BLD_RST_GENCTL 32'h8600025F
// fts count during power-on reset: separate clock field default
`define BLD_RST_FTS 8'h32

// writable bits; the rest read their fixed value
`define BLD_WMASK_DIAG 32'hFFFF1FBF
`define BLD_WMASK_GENCTL 32'hFEFFFFFF

// link diagnostics field positions
`define BLD_FTS_SEP_HI 31
`define BLD_FTS_SEP_LO 24
`define BLD_FTS_SHR_HI 23
`define BLD_FTS_SHR_LO 16
`define BLD_LAYER_REV_HI 15
`define BLD_LAYER_REV_LO 13
`define BLD_LINK_NUM_HI 12
`define BLD_LINK_NUM_LO 8
`define BLD_L2_SAVE_BIT 7
`define BLD_RSVD_RO_BIT 6
`define BLD_BASE_EN_BIT 5

// hardwired physical layer revision
`define BLD_LAYER_REV 3'h1

// subsystem alias field positions
`define BLD_SSID_HI 31
`define BLD_SSID_LO 16
`define BLD_SSVID_HI 15
`define BLD_SSVID_LO 0

`endif

// ---- pkg/bld_pkg.sv ----
// types for the bridge link diagnostic configuration register bank
// assumes bld_params.svh supplies offsets, reset values and field positions; select codes are set here
package bld_pkg;

   typedef logic [31:0] bld_word_t;

   typedef enum logic [2:0] {
      BLD_SEL_NONE = 3'b000,
      BLD_SEL_DIAG = 3'b001,
      BLD_SEL_SUBSYS = 3'b010,
      BLD_SEL_GENCTL = 3'b011,
      BLD_SEL_SSID = 3'b100
   } bld_sel_t;

endpackage : bld_pkg

// ---- src/bld_reset_sync.sv ----
// synchroniser for an active-low reset pin from outside the clock domain
// assumes the pin may change at any time relative to clk
`timescale 1ns/1ps

module bld_reset_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin_n,
   output logic reset_active
);

   logic s1_q, s2_q, s3_q, act_q;
   logic s1_d, s2_d, s3_d, act_d;

   // change accepted only once stages two and three agree
   always_comb begin
      s1_d = pin_n;
      s2_d = s1_q;
      s3_d = s2_q;
      act_d = act_q;
      if (s2_q == s3_q) begin
         act_d = ~s3_q;
      end
   end

   // power-on holds the pin as asserted until it is seen released
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         act_q <= 1'b1;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         act_q <= act_d;
      end
   end

   assign reset_active = act_q;

endmodule : bld_reset_sync

// ---- src/bld_config_regs.sv ----
// link diagnostics, subsystem alias and general control configuration
// registers of a bridge; assumes single-cycle config read/write strobes
// from the configuration decoder on CLK_SYS
`timescale 1ns/1ps
`include "bld_params.svh"

module bld_config_regs (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic FUND_RESET_N,
   input wire logic GLOBAL_RESET_INPUT_N,
   input wire logic [7:0] CFG_ADDR,
   input wire logic CFG_WR,
   input wire logic CFG_RD,
   input wire logic [3:0] CFG_BE,
   input wire logic [31:0] CFG_WDATA,
   output logic [31:0] CFG_RDATA,
   output logic CFG_RVALID,
   input wire logic COMMON_CLOCK_CONFIG_BIT,
   output logic [7:0] FTS_COUNT,
   output logic L2_POWER_SAVING_ENABLE,
   output logic FIRST_BASE_WINDOW_ENABLE,
   output logic [4:0] LINK_NUMBER,
   output logic [15:0] SUBSYSTEM_IDENT_FIELD,
   output logic [15:0] SUBSYSTEM_MAKER_FIELD,
   output logic [31:0] GENERAL_CONTROL
);

   logic fund_active;
   logic glob_active;
   logic soft_rst;
   bld_pkg::bld_word_t diag_q;
   bld_pkg::bld_word_t diag_d;
   bld_pkg::bld_word_t subsys_q;
   bld_pkg::bld_word_t subsys_d;
   bld_pkg::bld_word_t genctl_q;
   bld_pkg::bld_word_t genctl_d;
   bld_pkg::bld_word_t rdata_q;
   bld_pkg::bld_word_t rdata_d;
   logic rvalid_q;
   logic rvalid_d;
   logic [7:0] fts_q;
   logic [7:0] fts_d;
   bld_pkg::bld_sel_t sel;

   function automatic bld_pkg::bld_sel_t decode(input logic [7:0] addr);
      case (addr)
         `BLD_OFS_DIAG: decode = bld_pkg::BLD_SEL_DIAG;
         `BLD_OFS_SUBSYS: decode = bld_pkg::BLD_SEL_SUBSYS;
         `BLD_OFS_GENCTL: decode = bld_pkg::BLD_SEL_GENCTL;
         `BLD_OFS_SSID: decode = bld_pkg::BLD_SEL_SSID;
         default: decode = bld_pkg::BLD_SEL_NONE;
      endcase
   endfunction : decode

   // byte-enabled merge limited to the writable bits
   function automatic bld_pkg::bld_word_t merge(
      input bld_pkg::bld_word_t old_val,
      input bld_pkg::bld_word_t new_val,
      input logic [3:0] be,
      input bld_pkg::bld_word_t wmask);
      bld_pkg::bld_word_t m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
      merge = (old_val & ~m) | (new_val & m);
   endfunction : merge

   // fixed fields overlaid on every read of the diagnostics word
   function automatic bld_pkg::bld_word_t diag_view(
      input bld_pkg::bld_word_t v);
      bld_pkg::bld_word_t r;
      r = v;
      r[`BLD_LAYER_REV_HI:`BLD_LAYER_REV_LO] = `BLD_LAYER_REV;
      r[`BLD_RSVD_RO_BIT] = 1'b0;
      diag_view = r;
   endfunction : diag_view

   // field picked by the link's clock mode
   function automatic logic [7:0] fts_pick(
      input bld_pkg::bld_word_t v,
      input logic shared_clk);
      logic [7:0] f;
      if (shared_clk) begin
         f = v[`BLD_FTS_SHR_HI:`BLD_FTS_SHR_LO];
      end else begin
         f = v[`BLD_FTS_SEP_HI:`BLD_FTS_SEP_LO];
      end
      fts_pick = f;
   endfunction : fts_pick

   bld_reset_sync u_fund_sync (
      .clk(CLK_SYS),
      .rst(RST),
      .pin_n(FUND_RESET_N),
      .reset_active(fund_active)
   );

   bld_reset_sync u_glob_sync (
      .clk(CLK_SYS),
      .rst(RST),
      .pin_n(GLOBAL_RESET_INPUT_N),
      .reset_active(glob_active)
   );

   assign soft_rst = fund_active | glob_active;
   assign sel = decode(CFG_ADDR);

   always_comb begin
      diag_d = diag_q;
      subsys_d = subsys_q;
      genctl_d = genctl_q;
      if (CFG_WR) begin
         case (sel)
            bld_pkg::BLD_SEL_DIAG: begin
               diag_d = merge(diag_q, CFG_WDATA, CFG_BE, `BLD_WMASK_DIAG);
            end
            bld_pkg::BLD_SEL_SUBSYS: begin
               subsys_d = merge(subsys_q, CFG_WDATA, CFG_BE, 32'hFFFFFFFF);
            end
            bld_pkg::BLD_SEL_GENCTL: begin
               genctl_d = merge(genctl_q, CFG_WDATA, CFG_BE,
                                `BLD_WMASK_GENCTL);
            end
            default: begin
               diag_d = diag_q;
            end
         endcase
      end
      // reset pins restore defaults, override writes
      // a write landing inside a soft reset is lost on purpose
      if (soft_rst) begin
         diag_d = `BLD_RST_DIAG;
         subsys_d = `BLD_RST_SUBSYS;
         genctl_d = `BLD_RST_GENCTL;
      end
   end

   // reads answer from the stored words, so a write in the same
   // cycle is seen only by the next read
   always_comb begin
      rdata_d = rdata_q;
      rvalid_d = 1'b0;
      if (CFG_RD) begin
         rvalid_d = 1'b1;
         case (sel)
            bld_pkg::BLD_SEL_DIAG: rdata_d = diag_view(diag_q);
            bld_pkg::BLD_SEL_SUBSYS: rdata_d = subsys_q;
            bld_pkg::BLD_SEL_SSID: rdata_d = subsys_q;
            bld_pkg::BLD_SEL_GENCTL: rdata_d = genctl_q;
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   // fts count by clock mode
   // taken from the next value so it moves on the same edge as the word
   always_comb begin
      fts_d = fts_pick(diag_d, COMMON_CLOCK_CONFIG_BIT);
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         diag_q <= `BLD_RST_DIAG;
         subsys_q <= `BLD_RST_SUBSYS;
         genctl_q <= `BLD_RST_GENCTL;
      end else begin
         diag_q <= diag_d;
         subsys_q <= subsys_d;
         genctl_q <= genctl_d;
      end
   end

   // read answer registers
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         rdata_q <= 32'h00000000;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         fts_q <= `BLD_RST_FTS;
      end else begin
         fts_q <= fts_d;
      end
   end

   assign CFG_RDATA = rdata_q;
   assign CFG_RVALID = rvalid_q;
   assign FTS_COUNT = fts_q;
   assign L2_POWER_SAVING_ENABLE = diag_q[`BLD_L2_SAVE_BIT];
   assign FIRST_BASE_WINDOW_ENABLE = diag_q[`BLD_BASE_EN_BIT];
   assign LINK_NUMBER = diag_q[`BLD_LINK_NUM_HI:`BLD_LINK_NUM_LO];
   assign SUBSYSTEM_IDENT_FIELD = subsys_q[`BLD_SSID_HI:`BLD_SSID_LO];
   assign SUBSYSTEM_MAKER_FIELD = subsys_q[`BLD_SSVID_HI:`BLD_SSVID_LO];
   assign GENERAL_CONTROL = genctl_q;

endmodule : bld_config_regs

// ---- verif/bld_chk_assertions.sv ----
// checker: config read view against the live field outputs
// assumes one clock domain and the top module's ports only
`timescale 1ns/1ps
`include "bld_params.svh"
module bld_chk (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic [7:0] CFG_ADDR,
   input wire logic CFG_WR,
   input wire logic CFG_RD,
   input wire logic [31:0] CFG_RDATA,
   input wire logic CFG_RVALID,
   input wire logic COMMON_CLOCK_CONFIG_BIT,
   input wire logic [7:0] FTS_COUNT,
   input wire logic L2_POWER_SAVING_ENABLE,
   input wire logic FIRST_BASE_WINDOW_ENABLE,
   input wire logic [4:0] LINK_NUMBER,
   input wire logic [15:0] SUBSYSTEM_IDENT_FIELD,
   input wire logic [15:0] SUBSYSTEM_MAKER_FIELD
);
   // pure reads only: a write in the same cycle moves the fields
   wire logic rd_diag = CFG_RD && !CFG_WR && CFG_ADDR == `BLD_OFS_DIAG;
   wire logic rd_alias = CFG_RD && !CFG_WR && CFG_ADDR == `BLD_OFS_SSID;
   wire logic ccb = COMMON_CLOCK_CONFIG_BIT;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   chk_fts_separate: assert property (
      rd_diag && !ccb |=> FTS_COUNT == CFG_RDATA[31:24])
      else $error("fts count not from separate clock field");
   chk_fts_shared: assert property (
      rd_diag && ccb |=> FTS_COUNT == CFG_RDATA[23:16])
      else $error("fts count not from shared clock field");
   chk_l2_save: assert property (
      rd_diag |=> L2_POWER_SAVING_ENABLE == CFG_RDATA[7])
      else $error("l2 saving output differs from bit 7");
   chk_fixed_bits: assert property (
      rd_diag |=> CFG_RDATA[6] == 1'b0 &&
         CFG_RDATA[15:13] == `BLD_LAYER_REV)
      else $error("fixed diag bits read wrong");
   chk_base_window: assert property (
      rd_diag |=> FIRST_BASE_WINDOW_ENABLE == CFG_RDATA[5])
      else $error("base window output differs from bit 5");
   chk_link_num: assert property (
      rd_diag |=> LINK_NUMBER == CFG_RDATA[12:8])
      else $error("link number output differs from read");
   chk_alias_view: assert property (
      rd_alias |=> CFG_RDATA ==
         {SUBSYSTEM_IDENT_FIELD, SUBSYSTEM_MAKER_FIELD})
      else $error("subsystem alias view differs");
   chk_rvalid_one: assert property (
      1'b1 |=> CFG_RVALID == $past(CFG_RD))
      else $error("read valid not one cycle after read");
   cover property (rd_diag && ccb);
   cover property (CFG_WR && CFG_ADDR == `BLD_OFS_SUBSYS);
   cover property (rd_alias);
endmodule : bld_chk

bind bld_config_regs bld_chk u_chk (.*);

// ---- verif/bld_host_model.sv ----
// host model: configuration software issuing single-cycle strobes
// assumes the block samples strobes on the rising clock edge
`timescale 1ns/1ps
module bld_host_model (
   input wire logic clk,
   output logic [7:0] addr,
   output logic wr,
   output logic rd,
   output logic [3:0] be,
   output logic [31:0] wdata,
   input wire logic [31:0] rdata
);
   initial begin
      addr = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      be = 4'h0;
      wdata = 32'h0;
   end
   task wr_cyc(input logic [7:0] a, input logic [3:0] b,
      input logic [31:0] d);
      @(posedge clk);
      #1;
      addr = a;
      be = b;
      wdata = (a == 8'hC8) ? {d[31:5], 5'h00} : d;
      wr = 1'b1;
      @(posedge clk);
      #1;
      wr = 1'b0;
      // idle data is not kept: invert it
      wdata = ~wdata;
   endtask : wr_cyc
   task rd_cyc(input logic [7:0] a, output logic [31:0] q);
      @(posedge clk);
      #1;
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1;
      rd = 1'b0;
      q = rdata;
   endtask : rd_cyc
endmodule : bld_host_model

// ---- verif/bridge_link_diag_config_regs_tb.sv ----
// bench for the link diagnostics register bank
// assumes the host model drives all config strobes
`timescale 1ns/1ps
module bridge_link_diag_config_regs_tb;
   logic clk, rst, fund_n, glob_n, ccb, wr, rd, rv;
   logic [7:0] addr, fts;
   logic [3:0] be;
   logic [31:0] wd, rdat, gc;
   logic l2, base;
   logic [4:0] link;
   logic [15:0] sid, svid;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   bld_config_regs DUT (.CLK_SYS(clk), .RST(rst), .FUND_RESET_N(fund_n),
      .GLOBAL_RESET_INPUT_N(glob_n), .CFG_ADDR(addr), .CFG_WR(wr),
      .CFG_RD(rd), .CFG_BE(be), .CFG_WDATA(wd), .CFG_RDATA(rdat),
      .CFG_RVALID(rv), .COMMON_CLOCK_CONFIG_BIT(ccb), .FTS_COUNT(fts),
      .L2_POWER_SAVING_ENABLE(l2), .FIRST_BASE_WINDOW_ENABLE(base),
      .LINK_NUMBER(link), .SUBSYSTEM_IDENT_FIELD(sid),
      .SUBSYSTEM_MAKER_FIELD(svid), .GENERAL_CONTROL(gc));
   bld_host_model u_host (.clk(clk), .addr(addr), .wr(wr), .rd(rd),
      .be(be), .wdata(wd), .rdata(rdat));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task close_out;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      u_host.rd_cyc(a, q);
      cmp(q, e);
   endtask : rc
   task dflt;
      rc(8'hC8, 32'h32142000);
      rc(8'hD0, 32'h00000000);
      rc(8'hD4, 32'h8600025F);
      rc(8'h44, 32'h00000000);
      rc(8'hC4, 32'h00000000);
      cmp(gc, 32'h8600025F);
      cmp({24'h0, fts}, ccb ? 32'h14 : 32'h32);
   endtask : dflt
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         close_out;
      end
   end
   initial begin
      {rst, fund_n, glob_n, ccb} = 4'b1110;
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      repeat (6) @(posedge clk);
      dflt;
      $display("reset view done");
      u_host.wr_cyc(8'hC8, 4'hF, 32'h5A3C1FFF);
      rc(8'hC8, 32'h5A3C3FA0);
      cmp({24'h0, fts}, 32'h5A);
      ccb = 1'b1;
      repeat (2) @(posedge clk);
      #1 cmp({24'h0, fts}, 32'h3C);
      rc(8'hC8, 32'h5A3C3FA0);
      cmp({25'h0, l2, base, link}, 32'h7F);
      u_host.wr_cyc(8'hC8, 4'h1, 32'h0);
      rc(8'hC8, 32'h5A3C3F00);
      cmp({30'h0, l2, base}, 32'h0);
      $display("diag fields done");
      u_host.wr_cyc(8'hD0, 4'hF, 32'h12345678);
      rc(8'h44, 32'h12345678);
      cmp({sid, svid}, 32'h12345678);
      u_host.wr_cyc(8'h44, 4'hF, 32'hFFFFFFFF);
      rc(8'hD0, 32'h12345678);
      u_host.wr_cyc(8'hD4, 4'hF, 32'hFFFFFFFF);
      rc(8'hD4, 32'hFEFFFFFF);
      cmp(gc, 32'hFEFFFFFF);
      $display("alias and control done");
      // k 0 fundamental, 1 global, 2 power-on reset in mid-run
      for (int k = 0; k < 3; k++) begin
         u_host.wr_cyc(8'hC8, 4'hF, 32'hFFFFFFFF);
         u_host.wr_cyc(8'hD0, 4'hF, 32'hA5A5A5A5);
         u_host.wr_cyc(8'hD4, 4'hF, 32'h00000000);
         if (k == 2) begin
            rst = 1'b1;
         end else begin
            {fund_n, glob_n} = (k == 0) ? 2'b01 : 2'b10;
         end
         repeat (6) @(posedge clk);
         #1 {rst, fund_n, glob_n} = 3'b011;
         repeat (6) @(posedge clk);
         dflt;
      end
      $display("soft resets done");
      close_out;
   end
endmodule : bridge_link_diag_config_regs_tb
